// ===== ssd_top.v
// Sixteen-step drum sequencer with APB register access
`timescale 1ns/10ps
`default_nettype none
`include "ssd_consts.vh"
module ssd_top #(
    parameter SCAN_CYC = `SSD_SCAN_CYC,
    parameter HUND_CYC = `SSD_HUND_CYC
) (
    input wire mclk, // 125 MHz clock
    input wire nrst, // Asynchronous reset, active low
    input wire psel, // APB select
    input wire penable, // APB access phase
    input wire pwrite, // APB direction, high writes
    input wire [7:0] paddr, // APB byte address
    input wire [31:0] pwdata, // APB write data
    output wire pready, // APB ready, zero wait
    output reg [31:0] prdata, // APB read data
    output wire pslverr, // APB error on unmapped address
    input wire [15:0] event_in, // Per-step event inputs
    output reg [15:0] out_pins, // Physical output points
    output wire seq_done // Completion flag
);

    // One-hot states
    localparam [2:0] ST_PROG = 3'b001;
    localparam [2:0] ST_RUN = 3'b010;
    localparam [2:0] ST_DONE = 3'b100;
    localparam [23:0] SCAN_LAST = SCAN_CYC - 1;
    localparam [23:0] HUND_LAST = HUND_CYC - 1;

    // Reset synchroniser
    reg [1:0] rst_sync_r;
    wire rst_n;

    // Dividers
    reg [23:0] scan_cnt_r;
    reg [23:0] hund_cnt_r;
    reg scan_en_r;
    reg scan_end_r;
    reg hund_pend_r;

    // Register file
    reg [15:0] ctrl_r;
    reg [15:0] preset_r;
    reg [15:0] tbase_r;
    reg [15:0] last_r;
    reg [15:0] even_r;
    reg [15:0] image_r;
    reg [15:0] count_tab [0:15];
    reg [15:0] pat_tab [0:15];
    reg [15:0] mask_tab [0:15];

    // The three step counters and control state
    reg [15:0] tick_r;
    reg [15:0] timer_r;
    reg [15:0] cur_r;
    reg [2:0] st_r;
    reg done_r;
    reg jog_prev_r;
    reg run_prev_r;

    // Next values
    reg [15:0] tick_nxt;
    reg [15:0] timer_nxt;
    reg [15:0] cur_nxt;
    reg [2:0] st_nxt;
    reg done_nxt;
    reg [15:0] image_nxt;

    integer i;

    // Step number 1..16 to table index 0..15
    function [3:0] step_idx;
        input [15:0] step;
        begin
            step_idx = step[3:0] - 4'h1;
        end
    endfunction

    // Address lies on a mapped word
    function map_ok;
        input [7:0] addr;
        begin
            map_ok = (addr[1:0] == 2'b00) &&
                ((addr[7:6] != 2'b00) || (addr[5:2] <= `SSD_A_SCALAR_TOP));
        end
    endfunction

    // Valid step number
    function step_ok;
        input [15:0] v;
        begin
            step_ok = (v >= `SSD_STEP_MIN) && (v <= `SSD_STEP_MAX);
        end
    endfunction

    // Release reset through two flops so the release is clean
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rst_sync_r <= 2'b00;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    // APB decode; the slave never stalls
    wire apb_setup = psel & ~penable;
    wire apb_wr = psel & penable & pwrite & map_ok(paddr);
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~map_ok(paddr);

    // Control fields
    wire c_start = ctrl_r[`SSD_C_START];
    wire c_jog = ctrl_r[`SSD_C_JOG];
    wire c_reset = ctrl_r[`SSD_C_RESET];
    wire c_run = ctrl_r[`SSD_C_RUN];
    wire c_ret = ctrl_r[`SSD_C_RET];
    wire [1:0] c_var = ctrl_r[`SSD_C_VAR_HI:`SSD_C_VAR_LO];
    wire is_timed = (c_var == `SSD_V_TIMED);
    wire is_masked = (c_var == `SSD_V_MASKED);

    // Scan and hundredth-second enables; a pending hundredth waits for the next scan
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            scan_cnt_r <= 24'h00_0000;
            hund_cnt_r <= 24'h00_0000;
            scan_en_r <= 1'b0;
            scan_end_r <= 1'b0;
            hund_pend_r <= 1'b0;
        end else begin
            scan_en_r <= (scan_cnt_r == SCAN_LAST);
            scan_end_r <= scan_en_r;
            if (scan_cnt_r == SCAN_LAST) begin
                scan_cnt_r <= 24'h00_0000;
            end else begin
                scan_cnt_r <= scan_cnt_r + 24'h00_0001;
            end
            if (hund_cnt_r == HUND_LAST) begin
                hund_cnt_r <= 24'h00_0000;
            end else begin
                hund_cnt_r <= hund_cnt_r + 24'h00_0001;
            end
            // A new hundredth beats the consume of the old one
            if (hund_cnt_r == HUND_LAST) begin
                hund_pend_r <= 1'b1;
            end else if (scan_en_r) begin
                hund_pend_r <= 1'b0;
            end
        end
    end

    // Per-step lookups
    wire [3:0] idx = step_idx(cur_r);
    wire [15:0] goal = count_tab[idx];
    wire ev_true = is_timed | ~even_r[idx] | event_in[idx];
    wire [15:0] timer_inc = timer_r + {15'h0000, hund_pend_r};
    wire tb_hit = hund_pend_r && (timer_inc >= tbase_r);
    wire [15:0] tick_inc = tick_r + 16'h0001;
    wire jog_rise = c_jog & ~jog_prev_r & ~is_timed;
    wire step_go = c_start & ev_true;
    // Unprogrammed count advances on the event alone
    wire step_fin = step_go & ((goal == 16'h0000) | (tb_hit & (tick_inc >= goal)));
    wire at_last = (cur_r >= last_r);

    // Next-state of the sequencer for one scan
    always @* begin
        tick_nxt = tick_r;
        timer_nxt = timer_r;
        cur_nxt = cur_r;
        st_nxt = st_r;
        done_nxt = done_r;
        case (st_r)
            ST_PROG: begin
                if (c_run) begin
                    // Run entry: non-retentive reinitialises, retentive resumes
                    if (!c_ret) begin
                        tick_nxt = 16'h0000;
                        timer_nxt = 16'h0000;
                        cur_nxt = preset_r;
                        done_nxt = 1'b0;
                        st_nxt = ST_RUN;
                    end else begin
                        st_nxt = done_r ? ST_DONE : ST_RUN;
                    end
                end
            end
            ST_RUN: begin
                if (!c_run) begin
                    st_nxt = ST_PROG;
                end else if (c_reset) begin
                    // Held at preset, nothing runs
                    cur_nxt = preset_r;
                    tick_nxt = 16'h0000;
                    timer_nxt = 16'h0000;
                end else if (jog_rise || step_fin) begin
                    tick_nxt = 16'h0000;
                    timer_nxt = 16'h0000;
                    if (at_last) begin
                        done_nxt = 1'b1;
                        st_nxt = ST_DONE;
                    end else begin
                        cur_nxt = cur_r + 16'h0001;
                    end
                end else if (step_go) begin
                    if (tb_hit) begin
                        timer_nxt = 16'h0000;
                        tick_nxt = tick_inc;
                    end else begin
                        timer_nxt = timer_inc;
                    end
                end
                // Otherwise start is low or the step event is false: everything freezes
            end
            ST_DONE: begin
                if (!c_run) begin
                    st_nxt = ST_PROG;
                end else if (c_reset) begin
                    done_nxt = 1'b0;
                    cur_nxt = preset_r;
                    tick_nxt = 16'h0000;
                    timer_nxt = 16'h0000;
                    st_nxt = ST_RUN;
                end
                // Start and jog have no effect here
            end
            default: begin
                st_nxt = ST_PROG;
            end
        endcase
    end

    // Output image: masked bits keep their state, others take the step pattern
    wire [3:0] nidx = step_idx(cur_nxt);
    wire [15:0] wmask = is_masked ? mask_tab[nidx] : `SSD_MASK_RST;
    always @* begin
        image_nxt = (image_r & ~wmask) | (pat_tab[nidx] & wmask);
    end

    // Sequencer state, scalar registers and output image
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r <= `SSD_CTRL_RST;
            preset_r <= `SSD_PRESET_RST;
            tbase_r <= `SSD_TBASE_RST;
            last_r <= `SSD_LAST_RST;
            even_r <= 16'h0000;
            image_r <= 16'h0000;
            out_pins <= 16'h0000;
            tick_r <= 16'h0000;
            timer_r <= 16'h0000;
            cur_r <= `SSD_PRESET_RST;
            st_r <= ST_PROG;
            done_r <= 1'b0;
            jog_prev_r <= 1'b0;
            run_prev_r <= 1'b0;
        end else begin
            // Software writes
            if (apb_wr && paddr == `SSD_A_CTRL) begin
                ctrl_r <= pwdata[15:0];
            end
            if (apb_wr && paddr == `SSD_A_PRESET && step_ok(pwdata[15:0])) begin
                preset_r <= pwdata[15:0];
            end
            if (apb_wr && paddr == `SSD_A_TBASE) begin
                tbase_r <= pwdata[15:0];
            end
            if (apb_wr && paddr == `SSD_A_LAST && step_ok(pwdata[15:0])) begin
                last_r <= pwdata[15:0];
            end
            if (apb_wr && paddr == `SSD_A_EVEN) begin
                even_r <= pwdata[15:0];
            end
            // One evaluation per scan; drum write of the image wins on the same cycle
            if (scan_en_r) begin
                tick_r <= tick_nxt;
                timer_r <= timer_nxt;
                cur_r <= cur_nxt;
                st_r <= st_nxt;
                done_r <= done_nxt;
                jog_prev_r <= c_jog;
                run_prev_r <= c_run;
                if (st_nxt != ST_PROG) begin
                    image_r <= image_nxt;
                end else if (apb_wr && paddr == `SSD_A_IMAGE) begin
                    image_r <= pwdata[15:0];
                end
            end else if (apb_wr && paddr == `SSD_A_IMAGE) begin
                image_r <= pwdata[15:0];
            end
            // Pins follow the image once the scan is over
            if (scan_end_r) begin
                out_pins <= image_r;
            end
        end
    end

    // Step tables
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            for (i = 0; i < 16; i = i + 1) begin
                count_tab[i] <= 16'h0000;
                pat_tab[i] <= 16'h0000;
                mask_tab[i] <= `SSD_MASK_RST;
            end
        end else if (apb_wr) begin
            case (paddr[7:6])
                `SSD_T_COUNT: count_tab[paddr[5:2]] <= pwdata[15:0];
                `SSD_T_PAT: pat_tab[paddr[5:2]] <= pwdata[15:0];
                `SSD_T_MASK: mask_tab[paddr[5:2]] <= pwdata[15:0];
                default: ;
            endcase
        end
    end

    // Read data is captured in the setup cycle, valid through the access phase
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h0000_0000;
        end else if (apb_setup) begin
            prdata <= 32'h0000_0000;
            if (map_ok(paddr)) begin
                case (paddr[7:6])
                    `SSD_T_COUNT: prdata[15:0] <= count_tab[paddr[5:2]];
                    `SSD_T_PAT: prdata[15:0] <= pat_tab[paddr[5:2]];
                    `SSD_T_MASK: prdata[15:0] <= mask_tab[paddr[5:2]];
                    default: begin
                        case (paddr)
                            `SSD_A_CTRL: prdata[15:0] <= ctrl_r;
                            `SSD_A_STAT: prdata[3:0] <= {st_r, done_r};
                            `SSD_A_TICK: prdata[15:0] <= tick_r;
                            `SSD_A_TIMER: prdata[15:0] <= timer_r;
                            `SSD_A_PRESET: prdata[15:0] <= preset_r;
                            `SSD_A_CUR: prdata[15:0] <= cur_r;
                            `SSD_A_TBASE: prdata[15:0] <= tbase_r;
                            `SSD_A_LAST: prdata[15:0] <= last_r;
                            `SSD_A_EVEN: prdata[15:0] <= even_r;
                            `SSD_A_IMAGE: prdata[15:0] <= image_r;
                            default: prdata <= 32'h0000_0000;
                        endcase
                    end
                endcase
            end
        end
    end

    assign seq_done = done_r;

endmodule
`default_nettype wire

// ===== ssd_consts.vh
// Constants for the sixteen-step sequencer: register map, fields, resets and timing
//
// Summary of operation
// - Completed state holds until reset or non-retentive run entry, then clears flag and loads preset.
// - Start acts only with reset low; runs timer or watches the step event.
// - Start and reset low freezes step, timer, counts and output pattern.
// - Each jog rising edge with reset low advances one step; timed variant ignores jog.
// - Reset beats start and forces the preset step.
// - Preset step is 1 to 16, entered on reset and on non-retentive run entry.
// - Each step has its own tick count; zero means unprogrammed on event variants.
// - Four counters hold step state and stay readable; the code keeps three: tick, timer and current step.
// - Each step has its own event input; it may be disabled on event variants.
// - Outputs are driven throughout run mode; non-retentive run entry shows preset pattern, masked.
// - Non-retentive run entry clears count and timer and loads current with preset.
// - Retentive mode, the default, keeps all counters across run entry.
// - Masked variants take one mask word per step from a sixteen-word table.
// - Mask bit 1 lets the drum write the output; 0 keeps the present state.
// - Output image copies to the output pins at the end of each scan.
// - While reset is high the step holds at preset, no timer, no events.
// - Last step completion sets the flag and keeps the current step value.
// - Jog moves to next step, clears timer; runs at once if start is high.
// - Jog in the final step completes the sequence like a normal finish.
// - Completion flag is the status bit of the first counter.
// - While the step event is true the timer runs; at the step count, advance.
// - Step time equals 0.01 s times timebase times step count.
`ifndef SSD_CONSTS_VH
`define SSD_CONSTS_VH
// Register byte addresses
`define SSD_A_CTRL 8'h00
`define SSD_A_STAT 8'h04
`define SSD_A_TICK 8'h08
`define SSD_A_TIMER 8'h0C
`define SSD_A_PRESET 8'h10
`define SSD_A_CUR 8'h14
`define SSD_A_TBASE 8'h18
`define SSD_A_LAST 8'h1C
`define SSD_A_EVEN 8'h20
`define SSD_A_IMAGE 8'h24
`define SSD_A_SCALAR_TOP 4'h9
// Table selects in address bits 7:6
`define SSD_T_COUNT 2'b01
`define SSD_T_PAT 2'b10
`define SSD_T_MASK 2'b11
// Control fields
`define SSD_C_START 0
`define SSD_C_JOG 1
`define SSD_C_RESET 2
`define SSD_C_RUN 3
`define SSD_C_RET 4
`define SSD_C_VAR_LO 5
`define SSD_C_VAR_HI 6
`define SSD_V_TIMED 2'b00
`define SSD_V_EVENT 2'b01
`define SSD_V_MASKED 2'b10
// Reset values
`define SSD_CTRL_RST 16'h0030
`define SSD_PRESET_RST 16'h0001
`define SSD_LAST_RST 16'h0010
`define SSD_TBASE_RST 16'h0001
`define SSD_MASK_RST 16'hFFFF
`define SSD_STEP_MIN 16'h0001
`define SSD_STEP_MAX 16'h0010
// Timing
`define SSD_CLK_NS 8
`define SSD_HUND_NS 10000000
`define SSD_HUND_CYC (`SSD_HUND_NS / `SSD_CLK_NS)
`define SSD_SCAN_NS 100000
`define SSD_SCAN_CYC (`SSD_SCAN_NS / `SSD_CLK_NS)
`endif

// ===== ssd_top_chk.sv
// Port-level assertion checker for the drum sequencer, bound to its top
`timescale 1ns/10ps
`default_nettype none
module ssd_top_chk #(
    parameter SCAN_CYC = 4,
    parameter HUND_CYC = 40
) (
    input wire logic mclk, // Clock
    input wire logic nrst, // Reset, low
    input wire logic psel, // Select
    input wire logic penable, // Access
    input wire logic pwrite, // Write
    input wire logic [7:0] paddr, // Address
    input wire logic [31:0] pwdata, // Wdata
    input wire logic pready, // Ready
    input wire logic [31:0] prdata, // Rdata
    input wire logic pslverr, // Error
    input wire logic [15:0] event_in, // Events
    input wire logic [15:0] out_pins, // Outputs
    input wire logic seq_done // Done flag
);
    logic [15:0] out_q;
    logic done_q;
    logic [7:0] chg_gap;
    logic [7:0] dn_gap;
    logic [7:0] wr_gap;
    logic [15:0] ctl_sh;
    wire logic acc = psel && penable;
    wire logic rd_cnt = acc && !pwrite && paddr >= 8'h08 && paddr <= 8'h14 && paddr[1:0] == 2'h0;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!nrst);
    // Gaps since the last pin change, last flag change and last write; the shadow tracks control
    // Pins trail the flag by one cycle, so each keeps its own gap
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            out_q <= 16'h0000;
            done_q <= 1'b0;
            chg_gap <= 8'hFF;
            dn_gap <= 8'hFF;
            wr_gap <= 8'hFF;
            ctl_sh <= 16'h0030;
        end else begin
            out_q <= out_pins;
            done_q <= seq_done;
            if (out_pins != out_q) begin
                chg_gap <= 8'h01;
            end else if (chg_gap != 8'hFF) begin
                chg_gap <= chg_gap + 8'h01;
            end
            if (seq_done != done_q) begin
                dn_gap <= 8'h01;
            end else if (dn_gap != 8'hFF) begin
                dn_gap <= dn_gap + 8'h01;
            end
            if (acc && pwrite) begin
                wr_gap <= 8'h00;
            end else if (wr_gap != 8'hFF) begin
                wr_gap <= wr_gap + 8'h01;
            end
            if (acc && pwrite && paddr == 8'h00) begin
                ctl_sh <= pwdata[15:0];
            end
        end
    end
    // Changes land only on scan edges, so two are at least a scan apart
    a_out_cadence: assert property ((out_pins != out_q) |-> chg_gap >= SCAN_CYC)
        else $error("outputs changed between scans");
    a_done_cadence: assert property ((seq_done != done_q) |-> dn_gap >= SCAN_CYC)
        else $error("done flag changed between scans");
    // Settle time of three scans keeps a just-written control out of the way
    a_freeze_hold: assert property (ctl_sh[3] && !ctl_sh[0] && !ctl_sh[2] && wr_gap > 3 * SCAN_CYC
        |=> $stable(out_pins) && $stable(seq_done))
        else $error("frozen sequencer moved");
    a_reset_hold: assert property (ctl_sh[2] && wr_gap > 3 * SCAN_CYC |-> !seq_done ##1 $stable(out_pins))
        else $error("sequencer ran under reset");
    a_done_stays: assert property (seq_done && wr_gap > 2 * SCAN_CYC |=> seq_done)
        else $error("done flag dropped by itself");
    a_done_clear: assert property ($fell(seq_done) |-> wr_gap <= 2 * SCAN_CYC)
        else $error("done flag cleared without control write");
    a_cur_range: assert property (acc && !pwrite && paddr == 8'h14
        |-> prdata[15:0] >= 16'h0001 && prdata[15:0] <= 16'h0010)
        else $error("current step out of range");
    a_cnt_read: assert property (rd_cnt |-> pready && !pslverr && prdata[31:16] == 16'h0000)
        else $error("counter read refused");
    c_done: cover property (seq_done && !done_q);
    c_reset: cover property (ctl_sh[2] && wr_gap > 3 * SCAN_CYC);
    c_freeze: cover property (ctl_sh[3] && !ctl_sh[0] && wr_gap > 3 * SCAN_CYC);
endmodule
bind ssd_top ssd_top_chk #(.SCAN_CYC(SCAN_CYC), .HUND_CYC(HUND_CYC)) ssd_top_chk_inst (
    .mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .event_in(event_in),
    .out_pins(out_pins), .seq_done(seq_done));
`default_nettype wire

// ===== ssd_ladder.sv
// Controlling-program model: APB master that writes controls and reads counters
`timescale 1ns/10ps
`default_nettype none
module ssd_ladder (
    input wire logic mclk, // Clock
    output var logic psel, // Select
    output var logic penable, // Access
    output var logic pwrite, // Write
    output var logic [7:0] paddr, // Address
    output var logic [31:0] pwdata, // Wdata
    input wire logic pready, // Ready
    input wire logic [31:0] prdata, // Rdata
    input wire logic pslverr // Error
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
    end
    // Any address may be written at any time; counters ignore writes and the preset takes only 1 to 16
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        int n;
        n = 0;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 64);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Released bus shows inverted values so stale data never looks valid
        paddr <= ~a;
        pwdata <= ~d;
    endtask
endmodule
`default_nettype wire

// ===== ssd_top_tb.sv
// Self-checking testbench for the drum sequencer
`timescale 1ns/10ps
`default_nettype none
module ssd_top_tb;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic [15:0] event_in = 16'h0000;
    wire logic psel, penable, pwrite, pready, pslverr, seq_done;
    wire logic [7:0] paddr;
    wire logic [31:0] pwdata, prdata;
    wire logic [15:0] out_pins;
    int error_cnt = 0;
    int samples_checked = 0;
    int k;
    logic [31:0] q;
    logic e;
    always #4 mclk = ~mclk;
    // Short scan and hundredth keep the run brief
    ssd_top #(.SCAN_CYC(4), .HUND_CYC(40)) ssd_top_inst (.mclk(mclk), .nrst(nrst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .event_in(event_in), .out_pins(out_pins), .seq_done(seq_done));
    ssd_ladder ssd_ladder_inst (.mclk(mclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr));
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] s, input logic [31:0] x);
        samples_checked++;
        if (s !== x) begin
            error_cnt++;
            $display("unexpected at %0t: got %h want %h", $time, s, x);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        ssd_ladder_inst.xfer(1'b1, a, d, q, e);
    endtask
    // Reads until the value shows or the read budget runs out
    task automatic rd(input logic [7:0] a, input logic [31:0] x, input int lim);
        int n;
        n = 0;
        do begin
            ssd_ladder_inst.xfer(1'b0, a, 32'h0000_0000, q, e);
            n++;
        end while (q !== x && n < lim);
        check(q, x);
    endtask
    task automatic pause(input int s);
        repeat (s * 4) @(posedge mclk);
    endtask
    // Jog level is held two scans high and two low so the edge is seen
    task automatic jog(input logic [7:0] b);
        wr(8'h00, {24'h00_0000, b | 8'h02});
        pause(2);
        wr(8'h00, {24'h00_0000, b});
        pause(2);
    endtask
    task automatic pins(input logic [15:0] x);
        check({16'h0000, out_pins}, {16'h0000, x});
    endtask
    initial begin
        repeat (20000) @(posedge mclk);
        error_cnt++;
        end_of_test;
    end
    initial begin
        repeat (6) @(posedge mclk);
        nrst <= 1'b1;
        repeat (3) @(posedge mclk);
        // Reset values, read-only counter, refused preset, unmapped address
        rd(8'h00, 32'h0000_0030, 1);
        rd(8'h10, 32'h0000_0001, 1);
        rd(8'h04, 32'h0000_0002, 1);
        wr(8'h08, 32'h0000_0007);
        rd(8'h08, 32'h0000_0000, 1);
        wr(8'h10, 32'h0000_0011);
        rd(8'h10, 32'h0000_0001, 1);
        rd(8'h28, 32'h0000_0000, 1);
        check({31'h0000_0000, e}, 32'h0000_0001);
        $display("test 1 ended");
        for (k = 0; k < 16; k++) begin
            wr(8'h40 + 8'(4 * k), 32'h0000_0001);
            wr(8'h80 + 8'(4 * k), 32'h0000_0001 << k);
        end
        wr(8'h1C, 32'h0000_0004);
        wr(8'h10, 32'h0000_0002);
        wr(8'h00, 32'h0000_0028);
        rd(8'h14, 32'h0000_0002, 20);
        rd(8'h0C, 32'h0000_0000, 1);
        pause(2);
        pins(16'h0002);
        jog(8'h28);
        rd(8'h14, 32'h0000_0003, 1);
        rd(8'h0C, 32'h0000_0000, 1);
        pause(10);
        rd(8'h14, 32'h0000_0003, 1);
        pins(16'h0004);
        wr(8'h00, 32'h0000_002D);
        rd(8'h14, 32'h0000_0002, 20);
        pause(20);
        rd(8'h08, 32'h0000_0000, 1);
        $display("test 2 ended");
        // Event gate on step 2, then timed steps to completion
        wr(8'h20, 32'h0000_0002);
        wr(8'h00, 32'h0000_0029);
        pause(30);
        rd(8'h14, 32'h0000_0002, 1);
        event_in <= 16'h0002;
        rd(8'h14, 32'h0000_0003, 100);
        rd(8'h04, 32'h0000_0009, 200);
        rd(8'h14, 32'h0000_0004, 1);
        check({31'h0000_0000, seq_done}, 32'h0000_0001);
        pins(16'h0008);
        jog(8'h29);
        rd(8'h14, 32'h0000_0004, 1);
        wr(8'h00, 32'h0000_002C);
        rd(8'h04, 32'h0000_0004, 20);
        $display("test 3 ended");
        // Jog through the last step, then retentive and plain run entry
        wr(8'h00, 32'h0000_0028);
        repeat (3) jog(8'h28);
        rd(8'h04, 32'h0000_0009, 20);
        wr(8'h00, 32'h0000_0010);
        wr(8'h00, 32'h0000_0018);
        pause(3);
        rd(8'h04, 32'h0000_0009, 1);
        wr(8'h00, 32'h0000_0000);
        wr(8'h00, 32'h0000_0008);
        rd(8'h04, 32'h0000_0004, 20);
        jog(8'h08);
        rd(8'h14, 32'h0000_0002, 1);
        // Masked step keeps the image, unmasked step writes its pattern
        wr(8'h00, 32'h0000_0040);
        wr(8'hC4, 32'h0000_0000);
        wr(8'h24, 32'h0000_00F0);
        wr(8'h00, 32'h0000_0048);
        pause(3);
        pins(16'h00F0);
        jog(8'h48);
        pins(16'h0004);
        $display("test 4 ended");
        end_of_test;
    end
endmodule
`default_nettype wire
